// ### rtl/pubkey_verify_validate.sv
`timescale 1ns/1ns
// Command interpreter for stored-key verify and key validate/invalidate
module pubkey_verify_validate #(
  parameter logic [7:0] SIGN_OPCODE = 8'h00, // Opcode byte placed in the signed message
  parameter logic [7:0] SERIAL_BYTE8 = 8'h5a, // Arbitrary value
  parameter logic [7:0] SERIAL_BYTE0 = 8'h3c, // Arbitrary value
  parameter logic [7:0] SERIAL_BYTE1 = 8'h7e // Arbitrary value
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmdGo,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] cmdMode,
  input wire logic [15:0] cmdParam2,
  input wire logic dataValid,
  input wire logic [7:0] dataByte,
  output logic cmdReady,
  input wire logic [255:0] ioKey,
  input wire logic [255:0] scratchKey,
  input wire logic [511:0] digestBuf,
  input wire logic [15:0] slotIsPubKey,
  input wire logic [15:0] slotNeedsValid,
  output logic outValid,
  output logic [7:0] outByte,
  output logic outLast,
  output logic outIsMac,
  input wire logic outReady,
  output logic engStart,
  output logic engFromStream,
  output logic engUseDigest,
  input wire logic engDone,
  input wire logic engOk,
  output logic slotWrite,
  output logic [3:0] slotWriteIdx,
  output logic [3:0] slotWriteNibble,
  output logic [63:0] slotNibbles,
  output logic respValid,
  output logic [7:0] respCode
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CHECK = 6'h02,
    ST_STREAM = 6'h04,
    ST_WAIT = 6'h08,
    ST_MACS = 6'h10,
    ST_RESP = 6'h20
  } state_t;

  state_t state_q; // Command sequencer state
  logic [7:0] opcode_q; // Latched command opcode
  logic [7:0] mode_q; // Latched mode byte
  logic [15:0] second_parameter_word_q; // Latched second parameter word
  logic [7:0] dataMem_q [0:82]; // Signature R, S and extra message bytes
  logic [6:0] dataCnt_q; // Data bytes received so far
  logic [3:0] nibble_q [0:pubkey_verify_pkg::SLOT_COUNT-1]; // Shadow of each slot's validity nibble
  logic macPhase_q; // Stream carries MAC input, not the signed message
  logic [7:0] respCode_q; // Answer held for the response cycle
  logic slotWrite_q; // One-cycle slot write strobe
  logic [3:0] slotWriteIdx_q; // Slot being written
  logic [3:0] slotWriteNibble_q; // Nibble being written
  logic [3:0] slot; // Slot addressed by the key identifier
  logic isValidate; // Validate or invalidate request
  logic isStored; // Plain stored-key verify request
  logic checkErr; // Command refused before any engine work
  logic walkStart; // Launch a byte walk
  logic [7:0] walkLen; // Length of that walk
  logic [7:0] walkIdx; // Byte position on the stream
  logic walkLast; // Last byte of the walk
  logic walkDone; // Last byte accepted
  logic [7:0] dataIdx; // Data memory index for the current byte
  logic [7:0] selByte; // Byte presented on the stream

  assign slot = second_parameter_word_q[3:0];
  assign isValidate = (mode_q == pubkey_verify_pkg::MODE_VALIDATE) ||
                      (mode_q == pubkey_verify_pkg::MODE_INVALIDATE);
  assign isStored = (mode_q == pubkey_verify_pkg::MODE_STORED_TK) ||
                    (mode_q == pubkey_verify_pkg::MODE_STORED_DB) ||
                    (mode_q == pubkey_verify_pkg::MODE_STORED_TK_MAC) ||
                    (mode_q == pubkey_verify_pkg::MODE_STORED_DB_MAC);

  // Refusal checks; all failures share one code distinct from 00 and 01
  always_comb begin
    checkErr = (opcode_q != pubkey_verify_pkg::OPC_VERIFY) || !(isValidate || isStored) ||
               (second_parameter_word_q[15:4] != pubkey_verify_pkg::KEYID_HIGH_ZERO) ||
               !slotIsPubKey[slot];
    if (isValidate) begin
      // Only policy-bound keys take part; short data or flag mismatch is an error
      checkErr = checkErr || !slotNeedsValid[slot] ||
                 (dataCnt_q != pubkey_verify_pkg::DATA_BYTES) ||
                 (dataMem_q[pubkey_verify_pkg::EXTRA_FLAG_AT][0] !=
                  mode_q[pubkey_verify_pkg::MODE_INV_BIT]);
    end else if (isStored) begin
      // A policy-bound key that is not validated cannot be used
      checkErr = checkErr || (dataCnt_q < pubkey_verify_pkg::SIG_BYTES) ||
                 (slotNeedsValid[slot] && nibble_q[slot] != pubkey_verify_pkg::NIB_VALID);
    end
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (cmdGo) state_q <= ST_CHECK;
        ST_CHECK: begin
          if (checkErr) state_q <= ST_RESP;
          else if (isValidate) state_q <= ST_STREAM;
          else state_q <= ST_WAIT;
        end
        ST_STREAM: if (walkDone) state_q <= ST_WAIT;
        ST_WAIT: begin
          if (engDone && engOk && isStored && mode_q[pubkey_verify_pkg::MODE_MAC_BIT]) begin
            state_q <= ST_MACS;
          end else if (engDone) begin
            state_q <= ST_RESP;
          end
        end
        ST_MACS: if (walkDone) state_q <= ST_RESP;
        ST_RESP: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Command fields are taken only while idle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      opcode_q <= 8'h00;
      mode_q <= 8'h00;
      second_parameter_word_q <= 16'h0000;
    end else if (state_q == ST_IDLE && cmdGo) begin
      opcode_q <= cmdOpcode;
      mode_q <= cmdMode;
      second_parameter_word_q <= cmdParam2;
    end
  end

  // Data field fill; bytes past the field size are dropped, count saturates
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dataCnt_q <= 7'h00;
    end else if (state_q == ST_RESP) begin
      dataCnt_q <= 7'h00;
    end else if (state_q == ST_IDLE && dataValid && dataCnt_q < pubkey_verify_pkg::DATA_BYTES) begin
      dataMem_q[dataCnt_q] <= dataByte;
      dataCnt_q <= 7'(dataCnt_q + 7'h01);
    end
  end

  // Walk launch: message before the engine, MAC input after a good verify
  assign walkStart = (state_q == ST_CHECK && !checkErr && isValidate) ||
                     (state_q == ST_WAIT && engDone && engOk && isStored &&
                      mode_q[pubkey_verify_pkg::MODE_MAC_BIT]);
  assign walkLen = isValidate ? pubkey_verify_pkg::MSG_LEN : pubkey_verify_pkg::MAC_LEN;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      macPhase_q <= 1'b0;
    end else if (walkStart) begin
      macPhase_q <= !isValidate;
    end
  end

  byte_walker walker (
    .clk(clk),
    .resetn(resetn),
    .start(walkStart),
    .len(walkLen),
    .ready(outReady),
    .idx(walkIdx),
    .valid(outValid),
    .last(walkLast),
    .done(walkDone)
  );

  // Byte selection for both layouts; serial bytes are fixed fill
  always_comb begin
    dataIdx = 8'h00;
    selByte = 8'h00;
    if (!macPhase_q) begin
      if (walkIdx < pubkey_verify_pkg::MSG_OPC_AT) begin
        selByte = scratchKey[{walkIdx[4:0], 3'b000} +: 8];
      end else if (walkIdx == pubkey_verify_pkg::MSG_OPC_AT) begin
        selByte = SIGN_OPCODE;
      end else if (walkIdx < pubkey_verify_pkg::MSG_SN8_AT) begin
        dataIdx = 8'(walkIdx - pubkey_verify_pkg::MSG_X0_AT + pubkey_verify_pkg::EXTRA_BASE);
        selByte = dataMem_q[dataIdx[6:0]];
      end else if (walkIdx == pubkey_verify_pkg::MSG_SN8_AT) begin
        selByte = SERIAL_BYTE8;
      end else if (walkIdx < pubkey_verify_pkg::MSG_SN0_AT) begin
        dataIdx = 8'(walkIdx - pubkey_verify_pkg::MSG_X10_AT + pubkey_verify_pkg::X10_OFS +
                     pubkey_verify_pkg::EXTRA_BASE);
        selByte = dataMem_q[dataIdx[6:0]];
      end else if (walkIdx == pubkey_verify_pkg::MSG_SN0_AT) begin
        selByte = SERIAL_BYTE0;
      end else if (walkIdx == pubkey_verify_pkg::MSG_SN1_AT) begin
        selByte = SERIAL_BYTE1;
      end else begin
        dataIdx = 8'(walkIdx - pubkey_verify_pkg::MSG_X14_AT + pubkey_verify_pkg::X14_OFS +
                     pubkey_verify_pkg::EXTRA_BASE);
        selByte = dataMem_q[dataIdx[6:0]];
      end
    end else begin
      if (walkIdx < pubkey_verify_pkg::MAC_MSG_AT) begin
        selByte = ioKey[{walkIdx[4:0], 3'b000} +: 8];
      end else if (walkIdx < pubkey_verify_pkg::MAC_NONCE_AT) begin
        // Message: digest buffer lower half, or the scratch key register
        selByte = mode_q[pubkey_verify_pkg::MODE_DB_BIT] ?
                  digestBuf[{1'b0, walkIdx[4:0], 3'b000} +: 8] :
                  scratchKey[{walkIdx[4:0], 3'b000} +: 8];
      end else if (walkIdx < pubkey_verify_pkg::MAC_R_AT) begin
        // Nonce sits in whichever half of the digest buffer the message left free
        selByte = digestBuf[{mode_q[pubkey_verify_pkg::MODE_DB_BIT], walkIdx[4:0], 3'b000} +: 8];
      end else if (walkIdx < pubkey_verify_pkg::MAC_OPC_AT) begin
        dataIdx = 8'(walkIdx - pubkey_verify_pkg::MAC_R_AT);
        selByte = dataMem_q[dataIdx[6:0]];
      end else if (walkIdx == pubkey_verify_pkg::MAC_OPC_AT) begin
        selByte = opcode_q;
      end else if (walkIdx == pubkey_verify_pkg::MAC_MODE_AT) begin
        selByte = mode_q;
      end else if (walkIdx == pubkey_verify_pkg::MAC_P2L_AT) begin
        selByte = second_parameter_word_q[7:0];
      end else begin
        selByte = second_parameter_word_q[15:8];
      end
    end
  end

  // Answer code chosen when the outcome is known
  always_ff @(posedge clk) begin
    if (!resetn) begin
      respCode_q <= pubkey_verify_pkg::RESP_OK;
    end else if (state_q == ST_CHECK && checkErr) begin
      respCode_q <= pubkey_verify_pkg::RESP_ERROR;
    end else if (state_q == ST_WAIT && engDone) begin
      respCode_q <= engOk ? pubkey_verify_pkg::RESP_OK : pubkey_verify_pkg::RESP_MISMATCH;
    end
  end

  // Validity shadow; written only after a verified validate or invalidate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < pubkey_verify_pkg::SLOT_COUNT; i++) begin
        nibble_q[i] <= (4'(i) == pubkey_verify_pkg::SHIPPED_SLOT) ?
                       pubkey_verify_pkg::NIB_VALID : pubkey_verify_pkg::NIB_INVALID;
      end
      slotWrite_q <= 1'b0;
      slotWriteIdx_q <= 4'h0;
      slotWriteNibble_q <= 4'h0;
    end else begin
      slotWrite_q <= 1'b0;
      if (state_q == ST_WAIT && engDone && engOk && isValidate) begin
        nibble_q[slot] <= mode_q[pubkey_verify_pkg::MODE_INV_BIT] ?
                          pubkey_verify_pkg::NIB_INVALID : pubkey_verify_pkg::NIB_VALID;
        slotWrite_q <= 1'b1;
        slotWriteIdx_q <= slot;
        slotWriteNibble_q <= mode_q[pubkey_verify_pkg::MODE_INV_BIT] ?
                             pubkey_verify_pkg::NIB_INVALID : pubkey_verify_pkg::NIB_VALID;
      end
    end
  end

  // Outputs
  assign cmdReady = (state_q == ST_IDLE);
  assign outByte = selByte;
  assign outLast = walkLast;
  assign outIsMac = macPhase_q;
  assign engStart = (state_q == ST_CHECK && !checkErr && isStored) ||
                    (state_q == ST_STREAM && walkDone);
  assign engFromStream = isValidate;
  assign engUseDigest = mode_q[pubkey_verify_pkg::MODE_DB_BIT];
  assign slotWrite = slotWrite_q;
  assign slotWriteIdx = slotWriteIdx_q;
  assign slotWriteNibble = slotWriteNibble_q;
  assign respValid = (state_q == ST_RESP);
  assign respCode = respCode_q;
  for (genvar g = 0; g < pubkey_verify_pkg::SLOT_COUNT; g++) begin : g_nib
    assign slotNibbles[4*g +: 4] = nibble_q[g];
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  bad_opcode_a: assert property (state_q == ST_CHECK && opcode_q != pubkey_verify_pkg::OPC_VERIFY
    |=> respValid && respCode == pubkey_verify_pkg::RESP_ERROR) else $error("opcode not refused");
  flag_mismatch_a: assert property (state_q == ST_CHECK && isValidate &&
    dataMem_q[pubkey_verify_pkg::EXTRA_FLAG_AT][0] != mode_q[pubkey_verify_pkg::MODE_INV_BIT]
    |=> respValid && respCode == pubkey_verify_pkg::RESP_ERROR) else $error("flag mismatch");
  unvalidated_use_a: assert property (state_q == ST_CHECK && isStored && slotNeedsValid[slot] &&
    nibble_q[slot] != pubkey_verify_pkg::NIB_VALID |-> !engStart ##1 respValid)
    else $error("unvalidated key used");
  nibble_cause_a: assert property ($changed(slotNibbles) |->
    $past(state_q == ST_WAIT && engDone && engOk && isValidate)) else $error("nibble changed");
  // Slot write strobe and the success answer share the response cycle
  nibble_value_a: assert property (slotWrite |-> slotWriteNibble ==
    (mode_q[pubkey_verify_pkg::MODE_INV_BIT] ? pubkey_verify_pkg::NIB_INVALID :
    pubkey_verify_pkg::NIB_VALID) && respValid && respCode == pubkey_verify_pkg::RESP_OK)
    else $error("wrong nibble");
  internal_slot_a: assert property (engStart && isValidate |-> $past(slotIsPubKey[slot], 2))
    else $error("external key validated");
  shipped_slot_a: assert property (!$past(resetn) |-> nibble_q[pubkey_verify_pkg::SHIPPED_SLOT] ==
    pubkey_verify_pkg::NIB_VALID) else $error("shipped slot invalid");
  mac_head_a: assert property (outValid && outIsMac && walkIdx < pubkey_verify_pkg::MAC_MSG_AT
    |-> outByte == ioKey[{walkIdx[4:0], 3'b000} +: 8]) else $error("MAC head wrong");
  mac_nonce_a: assert property (outValid && outIsMac && walkIdx >= pubkey_verify_pkg::MAC_NONCE_AT
    && walkIdx < pubkey_verify_pkg::MAC_R_AT && !mode_q[pubkey_verify_pkg::MODE_DB_BIT]
    |-> outByte == digestBuf[{1'b0, walkIdx[4:0], 3'b000} +: 8]) else $error("nonce wrong");
  mac_message_a: assert property (outValid && outIsMac && walkIdx >= pubkey_verify_pkg::MAC_MSG_AT
    && walkIdx < pubkey_verify_pkg::MAC_NONCE_AT && mode_q[pubkey_verify_pkg::MODE_DB_BIT]
    |-> outByte == digestBuf[{1'b0, walkIdx[4:0], 3'b000} +: 8]) else $error("message wrong");
  mac_tail_a: assert property (outValid && outIsMac && walkIdx == pubkey_verify_pkg::MAC_P2L_AT
    |-> outByte == second_parameter_word_q[7:0] && !outLast) else $error("param order wrong");
  msg_serial_a: assert property (outValid && !outIsMac && walkIdx == pubkey_verify_pkg::MSG_SN8_AT
    |-> outByte == SERIAL_BYTE8) else $error("serial byte wrong");
  mismatch_resp_a: assert property (state_q == ST_WAIT && engDone && !engOk
    |=> respValid && respCode == pubkey_verify_pkg::RESP_MISMATCH) else $error("bad answer");

  validate_ok_c: cover property (slotWrite && slotWriteNibble == pubkey_verify_pkg::NIB_VALID);
  invalidate_ok_c: cover property (slotWrite && slotWriteNibble == pubkey_verify_pkg::NIB_INVALID);
  mac_stream_c: cover property (outValid && outIsMac && outLast && outReady);
  refused_c: cover property (respValid && respCode == pubkey_verify_pkg::RESP_ERROR);
endmodule : pubkey_verify_validate

// ### rtl/pubkey_verify_pkg.sv
// Function
// - MAC input opens with IO protection key
// - Scratch message second, lower digest nonce third
// - Digest buffer: message low half, nonce high
// - Then R, S, opcode, mode, parameter LSB-first
// - Validity change only for internal key slots
// - Policy-bound keys need validation before verify use
// - Validity kept in slot byte 0 upper nibble
// - Opcode 45, validate mode 03, invalidate 07
// - Extra byte 17 bit 0 must match mode bit 2
// - Signed message interleaves extra and serial bytes
// - Answer 00 verified, 01 mismatch, else error
// - Success writes nibble 5 validate, A invalidate
// - Shipped slot 14 holds validated key
package pubkey_verify_pkg;
  // Command codes
  localparam logic [7:0] OPC_VERIFY = 8'h45;
  localparam logic [7:0] MODE_STORED_TK = 8'h00;
  localparam logic [7:0] MODE_STORED_DB = 8'h20;
  localparam logic [7:0] MODE_STORED_TK_MAC = 8'h80;
  localparam logic [7:0] MODE_STORED_DB_MAC = 8'ha0;
  localparam logic [7:0] MODE_VALIDATE = 8'h03;
  localparam logic [7:0] MODE_INVALIDATE = 8'h07;
  localparam int MODE_INV_BIT = 2;
  localparam int MODE_DB_BIT = 5;
  localparam int MODE_MAC_BIT = 7;
  // Response codes
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_MISMATCH = 8'h01;
  localparam logic [7:0] RESP_ERROR = 8'h0f;
  // Validity nibble codes and slots
  localparam logic [3:0] NIB_VALID = 4'h5;
  localparam logic [3:0] NIB_INVALID = 4'ha;
  localparam int SLOT_COUNT = 16;
  localparam logic [3:0] SHIPPED_SLOT = 4'he;
  localparam logic [11:0] KEYID_HIGH_ZERO = 12'h000;
  // Data field layout (signature R, S, then extra message bytes)
  localparam logic [6:0] SIG_BYTES = 7'h40;
  localparam logic [6:0] DATA_BYTES = 7'h53;
  localparam logic [6:0] EXTRA_FLAG_AT = 7'h51;
  localparam logic [7:0] EXTRA_BASE = 8'h40;
  // Signed message layout, byte positions
  localparam logic [7:0] MSG_LEN = 8'h37;
  localparam logic [7:0] MSG_OPC_AT = 8'h20;
  localparam logic [7:0] MSG_X0_AT = 8'h21;
  localparam logic [7:0] MSG_SN8_AT = 8'h2b;
  localparam logic [7:0] MSG_X10_AT = 8'h2c;
  localparam logic [7:0] MSG_SN0_AT = 8'h30;
  localparam logic [7:0] MSG_SN1_AT = 8'h31;
  localparam logic [7:0] MSG_X14_AT = 8'h32;
  localparam logic [7:0] X10_OFS = 8'h0a;
  localparam logic [7:0] X14_OFS = 8'h0e;
  // MAC input layout, byte positions
  localparam logic [7:0] MAC_LEN = 8'ha4;
  localparam logic [7:0] MAC_MSG_AT = 8'h20;
  localparam logic [7:0] MAC_NONCE_AT = 8'h40;
  localparam logic [7:0] MAC_R_AT = 8'h60;
  localparam logic [7:0] MAC_OPC_AT = 8'ha0;
  localparam logic [7:0] MAC_MODE_AT = 8'ha1;
  localparam logic [7:0] MAC_P2L_AT = 8'ha2;
endpackage : pubkey_verify_pkg

// ### rtl/byte_walker.sv
`timescale 1ns/1ns
// Walks a byte index from zero to len-1 under a valid/ready handshake
module byte_walker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic ready,
  output logic [7:0] idx,
  output logic valid,
  output logic last,
  output logic done
);
  logic busy_q; // Walk in progress
  logic [7:0] idx_q; // Current byte index
  logic [7:0] len_q; // Latched walk length

  assign idx = idx_q;
  assign valid = busy_q;
  assign last = (idx_q == 8'(len_q - 8'h01));
  assign done = busy_q && ready && last;

  // Busy flag: raised by start, dropped when the last byte is taken
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (done) begin
      busy_q <= 1'b0;
    end
  end

  // Index advances only on an accepted byte, so a stalled sink holds it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idx_q <= 8'h00;
      len_q <= 8'h00;
    end else if (start) begin
      idx_q <= 8'h00;
      len_q <= len;
    end else if (busy_q && ready && !last) begin
      idx_q <= 8'(idx_q + 8'h01);
    end
  end
endmodule : byte_walker

// ### tb/verify_engine_model.sv
`timescale 1ns/1ns
// Far-side model: signature engine plus the sink for the streamed bytes
module verify_engine_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic engStart,
  input wire logic outValid,
  input wire logic [7:0] outByte,
  input wire logic verdictOk,
  input wire logic slow,
  input wire logic clearCapture,
  output logic engDone,
  output logic engOk,
  output logic outReady
);
  logic [7:0] captured [0:255]; // Bytes taken from the stream
  int seenCount; // Number of bytes taken since the last clear
  int waitCount; // Cycles left before the verdict
  logic busy; // Engine is working on a request
  logic phase; // Alternating stall pattern for the slow sink

  // Engine answers after one cycle, or after twenty when slow
  always_ff @(posedge clk) begin
    if (!resetn) begin
      engDone <= 1'b0;
      busy <= 1'b0;
      waitCount <= 0;
    end else begin
      engDone <= 1'b0;
      if (engStart) begin
        busy <= 1'b1;
        waitCount <= slow ? 20 : 1;
      end else if (busy && waitCount == 1) begin
        busy <= 1'b0;
        engDone <= 1'b1;
      end else if (busy) begin
        waitCount <= waitCount - 1;
      end
    end
  end

  // Verdict only means something with the done pulse; otherwise show its inverse
  always_ff @(posedge clk) begin
    engOk <= (busy && waitCount == 1) ? verdictOk : ~verdictOk;
  end

  // Slow sink stalls every other cycle so the design must hold its byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end
  assign outReady = slow ? phase : 1'b1;

  // Capture every accepted stream byte
  always_ff @(posedge clk) begin
    if (!resetn || clearCapture) begin
      seenCount <= 0;
    end else if (outValid && outReady) begin
      captured[seenCount[7:0]] <= outByte;
      seenCount <= seenCount + 1;
    end
  end
endmodule : verify_engine_model

// ### tb/pubkey_verify_validate_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the verify and validate command interpreter
module pubkey_verify_validate_tb;
  localparam logic [7:0] SIGN_OPC = 8'h41; // Sign opcode placed in the message
  localparam logic [7:0] SER8 = 8'h5a; // Arbitrary value
  localparam logic [7:0] SER0 = 8'h3c; // Arbitrary value
  localparam logic [7:0] SER1 = 8'h7e; // Arbitrary value
  logic clk, resetn, cmdGo, dataValid, cmdReady, outValid, outLast, outIsMac, outReady;
  logic engStart, engFromStream, engUseDigest, engDone, engOk, slotWrite, respValid;
  logic [7:0] cmdOpcode, cmdMode, dataByte, outByte, respCode, lastResp, curOpc;
  logic [15:0] cmdParam2, slotIsPubKey, slotNeedsValid, curParam2;
  logic [255:0] ioKey, scratchKey;
  logic [511:0] digestBuf;
  logic [3:0] slotWriteIdx, slotWriteNibble;
  logic [63:0] slotNibbles;
  logic verdictOk, slow, clearCapture, flagBit; // Partner controls and current flag bit
  int mismatches, check_count;

  pubkey_verify_validate #(.SIGN_OPCODE(SIGN_OPC), .SERIAL_BYTE8(SER8),
    .SERIAL_BYTE0(SER0), .SERIAL_BYTE1(SER1)) dut_u (
    .clk(clk), .resetn(resetn), .cmdGo(cmdGo), .cmdOpcode(cmdOpcode), .cmdMode(cmdMode),
    .cmdParam2(cmdParam2), .dataValid(dataValid), .dataByte(dataByte), .cmdReady(cmdReady),
    .ioKey(ioKey), .scratchKey(scratchKey), .digestBuf(digestBuf),
    .slotIsPubKey(slotIsPubKey), .slotNeedsValid(slotNeedsValid), .outValid(outValid),
    .outByte(outByte), .outLast(outLast), .outIsMac(outIsMac), .outReady(outReady),
    .engStart(engStart), .engFromStream(engFromStream), .engUseDigest(engUseDigest),
    .engDone(engDone), .engOk(engOk), .slotWrite(slotWrite), .slotWriteIdx(slotWriteIdx),
    .slotWriteNibble(slotWriteNibble), .slotNibbles(slotNibbles), .respValid(respValid),
    .respCode(respCode));

  verify_engine_model model_u (.clk(clk), .resetn(resetn), .engStart(engStart),
    .outValid(outValid), .outByte(outByte), .verdictOk(verdictOk), .slow(slow),
    .clearCapture(clearCapture), .engDone(engDone), .engOk(engOk), .outReady(outReady));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Data field byte: same extra bytes every time, only byte 17 bit 0 follows the flag
  function automatic logic [7:0] dataAt(input int i);
    return (i == 81) ? {7'h2c, flagBit} : 8'(8'h11 + i);
  endfunction : dataAt

  // Expected stream byte: MAC input when mac is set, else the signed message
  function automatic logic [7:0] expByte(input logic mac, input logic [7:0] md, input int i);
    int x;
    x = (i < 43) ? i - 33 : (i < 48) ? i - 34 : i - 36;
    if (mac) begin
      if (i < 32) return ioKey[8*i +: 8];
      if (i < 64) return md[5] ? digestBuf[8*(i-32) +: 8] : scratchKey[8*(i-32) +: 8];
      if (i < 96) return digestBuf[8*(i-(md[5] ? 32 : 64)) +: 8];
      if (i < 160) return dataAt(i - 96);
      if (i == 160) return 8'h45;
      if (i == 161) return md;
      return (i == 162) ? curParam2[7:0] : curParam2[15:8];
    end
    if (i < 32) return scratchKey[8*i +: 8];
    if (i == 32) return SIGN_OPC;
    if (i == 43) return SER8;
    if (i == 48) return SER0;
    if (i == 49) return SER1;
    return dataAt(64 + x);
  endfunction : expByte

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Load the data field, launch the command and wait a bounded time for the answer
  task automatic runCmd(input logic [7:0] md, input logic [3:0] slot, input int n,
                        input logic flag);
    int k;
    flagBit = flag;
    curParam2 = {12'h000, slot};
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      dataValid <= 1'b1;
      dataByte <= dataAt(k);
      clearCapture <= 1'b1;
    end
    @(posedge clk);
    dataValid <= 1'b0;
    clearCapture <= 1'b0;
    cmdGo <= 1'b1;
    cmdOpcode <= curOpc;
    cmdMode <= md;
    cmdParam2 <= curParam2;
    @(posedge clk);
    cmdGo <= 1'b0;
    for (k = 0; k < 4000 && respValid !== 1'b1; k++) @(negedge clk);
    if (respValid !== 1'b1) begin
      mismatches++;
      conclude();
    end
    lastResp = respCode;
    @(posedge clk);
  endtask : runCmd

  task automatic testReset();
    @(negedge clk);
    check("ready after reset", 1, cmdReady);
    check("reset nibbles", 64'ha5aa_aaaa_aaaa_aaaa, slotNibbles);
    check("reset answer", 8'h00, respCode);
    @(posedge clk);
    $display("test reset done");
  endtask : testReset

  // Validate, refused invalidate, failed then good invalidate of slot 3
  task automatic testValidity();
    int i;
    slow <= 1'b1;
    verdictOk <= 1'b1;
    runCmd(8'h03, 4'h3, 83, 1'b0);
    check("validate answer", 8'h00, lastResp);
    check("validated nibble", 4'h5, slotNibbles[15:12]);
    check("write slot", 3, slotWriteIdx);
    check("stream source", 1, engFromStream);
    check("message length", 55, model_u.seenCount);
    for (i = 0; i < 55; i++) check("message byte", expByte(1'b0, 8'h03, i), model_u.captured[i]);
    runCmd(8'h07, 4'h3, 83, 1'b0);
    check("flag clash answer", 8'h0f, lastResp);
    check("nibble after clash", 4'h5, slotNibbles[15:12]);
    verdictOk <= 1'b0;
    runCmd(8'h07, 4'h3, 83, 1'b1);
    check("bad signature answer", 8'h01, lastResp);
    check("nibble after bad signature", 4'h5, slotNibbles[15:12]);
    verdictOk <= 1'b1;
    slow <= 1'b0;
    runCmd(8'h07, 4'h3, 83, 1'b1);
    check("invalidate answer", 8'h00, lastResp);
    check("invalidated nibble", 4'ha, slotNibbles[15:12]);
    runCmd(8'h03, 4'h9, 83, 1'b0);
    check("external slot answer", 8'h0f, lastResp);
    runCmd(8'h00, 4'h3, 64, 1'b0);
    check("unvalidated key answer", 8'h0f, lastResp);
    runCmd(8'h03, 4'h3, 82, 1'b0);
    check("short data answer", 8'h0f, lastResp);
    curOpc = 8'h46;
    runCmd(8'h03, 4'h3, 83, 1'b0);
    curOpc = 8'h45;
    check("bad opcode answer", 8'h0f, lastResp);
    check("nibble after refusal", 4'ha, slotNibbles[15:12]);
    $display("test validity done");
  endtask : testValidity

  // Stored-key verify in every mode on the shipped key, then a mismatch with MAC asked
  task automatic testStored();
    logic [7:0] modes [4] = '{8'h00, 8'h20, 8'h80, 8'ha0};
    int j;
    int i;
    int n;
    for (j = 0; j < 4; j++) begin
      slow <= j[0];
      runCmd(modes[j], 4'he, 64, 1'b0);
      n = modes[j][7] ? 164 : 0;
      check("stored answer", 8'h00, lastResp);
      check("digest select", modes[j][5], engUseDigest);
      check("stream length", n, model_u.seenCount);
      for (i = 0; i < n; i++) check("mac byte", expByte(1'b1, modes[j], i), model_u.captured[i]);
    end
    verdictOk <= 1'b0;
    runCmd(8'h80, 4'he, 64, 1'b0);
    check("mac mismatch answer", 8'h01, lastResp);
    check("mismatch stream", 0, model_u.seenCount);
    $display("test stored done");
  endtask : testStored

  // Main sequence
  initial begin
    resetn = 1'b0;
    cmdGo = 1'b0;
    dataValid = 1'b0;
    dataByte = 8'h00;
    cmdOpcode = 8'h00;
    curOpc = 8'h45;
    cmdMode = 8'h00;
    cmdParam2 = 16'h0000;
    slotIsPubKey = 16'hfdff;
    slotNeedsValid = 16'h4008;
    verdictOk = 1'b1;
    slow = 1'b0;
    clearCapture = 1'b0;
    flagBit = 1'b0;
    curParam2 = 16'h0000;
    mismatches = 0;
    check_count = 0;
    for (int i = 0; i < 32; i++) begin
      ioKey[8*i +: 8] = 8'(8'h80 + i);
      scratchKey[8*i +: 8] = 8'(8'hc7 ^ i);
    end
    for (int i = 0; i < 64; i++) digestBuf[8*i +: 8] = 8'(3 * i + 1);
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    testReset();
    testValidity();
    testStored();
    conclude();
  end
endmodule : pubkey_verify_validate_tb
